// [rtl/ulm_core.sv]
// line-mode uart: one-wire, rs-485 direction, infrared, parity, start-of-frame wake
`timescale 1ns/10ps
`include "ulm_map.svh"

module ulm_core (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // register bus
    input  wire ulm_pkg::ulm_apb_req_t apb_req,
    output ulm_pkg::ulm_apb_rsp_t      apb_rsp,
    // serial pins
    input  wire logic                  rxd_i,
    input  wire logic                  txd_i,
    output logic                       txd_o,
    output logic                       txd_oe_n,
    output logic                       line_driver_direction_o,
    input  wire logic                  ir_event_i,
    // power and interrupt
    input  wire logic                  standby_i,
    input  wire logic                  other_wake_i,
    output logic                       osc_req_o,
    output logic                       clk_req_o,
    output logic                       irq_o
);
    import ulm_pkg::*;

    ulm_state_t q;
    ulm_state_t d;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a[1:0] == 2'h0) && (a <= `ULM_OFF_IRCTL);
    endfunction

    // even gives one when the count of ones is odd
    function automatic logic par_of(input logic [7:0] v, input logic odd);
        par_of = (^v) ^ odd;
    endfunction

    logic        tick;
    logic        rs485;
    logic        loopback;
    logic        od;
    logic        ir_mode;
    logic        par_en;
    logic        par_odd;
    logic        lin_mode;
    logic [4:0]  ovs;
    logic [4:0]  half;
    logic        tx_end;
    logic        rx_tick_end;
    logic        tx_bit;
    logic        ir_pulse;
    logic        line_bit;
    logic        pin_raw;
    logic        ir_in;
    logic        rx_line;
    logic        rx_fall;
    logic        sof_arm;
    logic        acc;
    logic        done;
    logic        wr;
    logic        pid_ok;
    logic        frame_parity_error_flag;
    logic [31:0] rdata;

    always_comb begin
        d = q;
        tick     = (q.baud_cnt == 16'h0000);
        rs485    = q.ctrl_a[`ULM_A_RS485];
        loopback = q.ctrl_a[`ULM_A_LOOPBACK];
        od       = q.ctrl_b[`ULM_B_OPEN_DRAIN];
        ir_mode  = (q.ctrl_c[`ULM_C_MODE_HI:`ULM_C_MODE_LO] == `ULM_MODE_IR);
        par_en   = q.ctrl_c[`ULM_C_PAR_HI];
        par_odd  = q.ctrl_c[`ULM_C_PAR_LO];
        lin_mode = (q.ctrl_b[`ULM_B_SPD_HI:`ULM_B_SPD_LO] == `ULM_SPD_LIN);
        ovs = (q.ctrl_b[`ULM_B_SPD_HI:`ULM_B_SPD_LO] == `ULM_SPD_DOUBLE) ?
              `ULM_OVS_DOUBLE : `ULM_OVS_NORMAL;
        half = ovs >> 1;
        tx_end      = tick && (q.tx_sub == ovs - 5'h01);
        rx_tick_end = tick && (q.rx_sub == ovs - 5'h01);

        // ****************************************
        // pin synchronisers and baud tick
        // ****************************************
        d.sync1    = {ir_event_i, txd_i, rxd_i};
        d.sync2    = q.sync1;
        d.baud_cnt = tick ? q.baud : q.baud_cnt - 16'h0001;

        // ****************************************
        // register bus
        // ****************************************
        acc  = apb_req.psel && apb_req.penable;
        done = acc && q.rsp.pready;
        wr   = done && apb_req.pwrite && addr_hit(apb_req.paddr);
        case (apb_req.paddr)
            `ULM_OFF_CTRL_A: rdata = {24'h000000, q.ctrl_a};
            `ULM_OFF_CTRL_B: rdata = {24'h000000, q.ctrl_b};
            `ULM_OFF_CTRL_C: rdata = {24'h000000, q.ctrl_c};
            `ULM_OFF_BAUD:   rdata = {16'h0000, q.baud};
            `ULM_OFF_RXDATA: rdata = {16'h0000, q.rxc, 4'h0, q.ferr, q.parity_error_flag, 1'b0, q.rx_data};
            `ULM_OFF_STATUS: rdata = {24'h000000, q.rxc, 2'h0, q.rxs, 2'h0,
                                      q.rx_st != RX_IDLE, q.tx_st != TX_IDLE};
            `ULM_OFF_IRCTL:  rdata = {7'h00, q.ir_evsel, 6'h00, q.irtx_mode,
                                      1'b0, q.rxpl, q.txpl};
            default:         rdata = 32'h00000000;
        endcase
        d.rsp.pready  = acc && !q.rsp.pready;
        d.rsp.pslverr = acc && !q.rsp.pready && !addr_hit(apb_req.paddr);
        if (acc && !q.rsp.pready) begin
            d.rsp.prdata = rdata;
        end
        if (wr) begin
            case (apb_req.paddr)
                `ULM_OFF_CTRL_A: d.ctrl_a = apb_req.pwdata[7:0];
                `ULM_OFF_CTRL_B: d.ctrl_b = apb_req.pwdata[7:0];
                `ULM_OFF_CTRL_C: d.ctrl_c = apb_req.pwdata[7:0];
                `ULM_OFF_BAUD:   d.baud = apb_req.pwdata[15:0];
                `ULM_OFF_IRCTL: begin
                    d.txpl      = apb_req.pwdata[7:0];
                    d.rxpl      = apb_req.pwdata[14:8];
                    d.irtx_mode = apb_req.pwdata[17:16];
                    d.ir_evsel  = apb_req.pwdata[24];
                end
                `ULM_OFF_STATUS: begin
                    if (apb_req.pwdata[`ULM_ST_RXS]) begin
                        d.rxs = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // reading received data consumes it; a new frame below still wins
        if (done && !apb_req.pwrite && apb_req.paddr == `ULM_OFF_RXDATA) begin
            d.rxc = 1'b0;
        end

        // ****************************************
        // transmitter
        // ****************************************
        if (q.tx_st != TX_IDLE && tick) begin
            d.tx_sub = tx_end ? 5'h00 : q.tx_sub + 5'h01;
        end
        d.tx_pw = (tx_end || q.tx_pw == 8'hFF) ? q.tx_pw : q.tx_pw + 8'h01;
        if (tx_end) begin
            d.tx_pw = 8'h00;
        end
        case (q.tx_st)
            TX_IDLE: begin
                if (wr && apb_req.paddr == `ULM_OFF_TXDATA && q.ctrl_b[`ULM_B_TX_EN]) begin
                    d.tx_shift = apb_req.pwdata[7:0];
                    d.tx_par   = par_of(apb_req.pwdata[7:0], par_odd);
                    d.tx_sub   = 5'h00;
                    d.tx_pw    = 8'h00;
                    d.tx_st    = rs485 ? TX_GUARD : TX_START;
                end
            end
            TX_GUARD: begin
                if (tx_end) begin
                    d.tx_st = TX_START;
                end
            end
            TX_START: begin
                if (tx_end) begin
                    d.tx_bitn = 3'h0;
                    d.tx_st   = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_end) begin
                    d.tx_shift = {1'b1, q.tx_shift[7:1]};
                    d.tx_bitn  = q.tx_bitn + 3'h1;
                    d.tx_stopn = 1'b0;
                    if (q.tx_bitn == 3'h7) begin
                        d.tx_st = par_en ? TX_PAR : TX_STOP;
                    end
                end
            end
            TX_PAR: begin
                if (tx_end) begin
                    d.tx_st = TX_STOP;
                end
            end
            TX_STOP: begin
                if (tx_end) begin
                    d.tx_stopn = 1'b1;
                    if (!q.ctrl_c[`ULM_C_STOP2] || q.tx_stopn) begin
                        d.tx_st = TX_IDLE;
                    end
                end
            end
            default: d.tx_st = TX_IDLE;
        endcase
        case (q.tx_st)
            TX_START: tx_bit = 1'b0;
            TX_DATA:  tx_bit = q.tx_shift[0];
            TX_PAR:   tx_bit = q.tx_par;
            default:  tx_bit = 1'b1;
        endcase
        // infrared pulse stands for a zero bit
        case (q.irtx_mode)
            `ULM_IRTX_316:   ir_pulse = !tx_bit && q.tx_sub < `ULM_IR_316_TICKS;
            `ULM_IRTX_FIXED: ir_pulse = !tx_bit && q.tx_pw < q.txpl;
            default:         ir_pulse = !tx_bit;
        endcase
        line_bit = ir_mode ? !ir_pulse : tx_bit;
        // open drain: drive only low, release otherwise, no direction bit needed
        d.txd      = od ? 1'b0 : line_bit;
        d.txd_oe_n = od ? line_bit : !q.ctrl_b[`ULM_B_TX_EN];
        // direction covers guard bit through final stop, loopback untouched
        d.line_driver_direction = rs485 && (q.tx_st != TX_IDLE);

        // ****************************************
        // receive source and infrared decoder
        // ****************************************
        // loopback listens on the tx pin itself, so it hears its own frames
        pin_raw = loopback ? q.sync2[1] : q.sync2[0];
        ir_in   = q.ir_evsel ? q.sync2[2] : !pin_raw;
        d.ir_cnt = ir_in ? ((q.ir_cnt == 7'h7F) ? q.ir_cnt : q.ir_cnt + 7'h01) : 7'h00;
        if (tick && q.ir_low != 5'h00) begin
            d.ir_low = q.ir_low - 5'h01;
        end
        // only a pulse reaching the minimum width yields a zero bit
        if (ir_in && q.ir_cnt == q.rxpl) begin
            d.ir_low = ovs;
        end
        rx_line   = ir_mode ? (q.ir_low == 5'h00) : pin_raw;
        d.rx_prev = rx_line;
        rx_fall   = q.rx_prev && !rx_line;

        // ****************************************
        // receiver
        // ****************************************
        sof_arm = standby_i && q.ctrl_b[`ULM_B_SOF_EN] &&
                  (q.ctrl_c[`ULM_C_MODE_HI:`ULM_C_MODE_LO] == `ULM_MODE_ASYNC);
        pid_ok = (q.rx_shift[6] == (q.rx_shift[0] ^ q.rx_shift[1] ^ q.rx_shift[2] ^
                  q.rx_shift[4])) &&
                 (q.rx_shift[7] == !(q.rx_shift[1] ^ q.rx_shift[3] ^ q.rx_shift[4] ^
                  q.rx_shift[5]));
        frame_parity_error_flag = lin_mode ? (q.lin_st == LIN_PID && !pid_ok) :
                     (par_en && q.rx_parbit != par_of(q.rx_shift, par_odd));
        if (q.rx_st != RX_IDLE && tick) begin
            d.rx_sub = q.rx_sub + 5'h01;
        end
        case (q.rx_st)
            RX_IDLE: begin
                if (rx_fall && q.ctrl_b[`ULM_B_RX_EN]) begin
                    d.rx_sub = 5'h00;
                    d.rx_st  = RX_START;
                    if (sof_arm) begin
                        d.rxs      = 1'b1;
                        d.sof_woke = 1'b1;
                        d.osc_hold = 1'b1;
                        if (q.ctrl_a[`ULM_A_RXS_IE]) begin
                            d.clk_wake = 1'b1;
                        end
                    end
                end
            end
            RX_START: begin
                if (tick && q.rx_sub == half - 5'h01) begin
                    d.rx_sub = 5'h00;
                    if (rx_line) begin
                        // glitch: give the oscillator back unless something else woke us
                        d.rx_st = RX_IDLE;
                        if (!other_wake_i) begin
                            d.osc_hold = 1'b0;
                            d.clk_wake = 1'b0;
                        end
                        d.sof_woke = 1'b0;
                    end else begin
                        d.rx_bitn = 3'h0;
                        d.rx_st   = RX_DATA;
                    end
                end
            end
            RX_DATA: begin
                if (rx_tick_end) begin
                    d.rx_sub   = 5'h00;
                    d.rx_shift = {rx_line, q.rx_shift[7:1]};
                    d.rx_bitn  = q.rx_bitn + 3'h1;
                    if (q.rx_bitn == 3'h7) begin
                        d.rx_st = par_en ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rx_tick_end) begin
                    d.rx_sub    = 5'h00;
                    d.rx_parbit = rx_line;
                    d.rx_st     = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_tick_end) begin
                    d.rx_sub  = 5'h00;
                    d.rx_st   = RX_IDLE;
                    d.rx_data = q.rx_shift;
                    d.ferr    = !rx_line;
                    d.parity_error_flag    = frame_parity_error_flag;
                    d.rxc     = 1'b1;
                    if (q.rx_shift == 8'h00 && !rx_line) begin
                        d.lin_st = LIN_SYNC;
                    end else if (q.lin_st == LIN_SYNC) begin
                        d.lin_st = LIN_PID;
                    end else begin
                        d.lin_st = LIN_WAIT;
                    end
                    if (q.sof_woke) begin
                        d.sof_woke = 1'b0;
                        d.osc_hold = 1'b0;
                        if (q.ctrl_a[`ULM_A_RXC_IE]) begin
                            d.clk_wake = 1'b1;
                        end
                    end
                end
            end
            default: d.rx_st = RX_IDLE;
        endcase
        if (!standby_i) begin
            d.osc_hold = 1'b0;
            d.clk_wake = 1'b0;
        end

        // ****************************************
        // power requests and shared interrupt
        // ****************************************
        // busy logic holds the oscillator even when sleep is requested
        d.osc_req = !standby_i || q.osc_hold || q.rx_st != RX_IDLE ||
                    q.tx_st != TX_IDLE;
        d.clk_req = !standby_i || q.clk_wake;
        d.irq = (q.rxs && q.ctrl_a[`ULM_A_RXS_IE]) ||
                (q.rxc && q.ctrl_a[`ULM_A_RXC_IE]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            q.sync1    <= 3'h3;
            q.sync2    <= 3'h3;
            q.baud     <= `ULM_BAUD_RST;
            q.txpl     <= `ULM_TXPL_RST;
            q.rxpl     <= `ULM_RXPL_RST;
            q.tx_st    <= TX_IDLE;
            q.rx_st    <= RX_IDLE;
            q.lin_st   <= LIN_WAIT;
            q.rx_prev  <= 1'b1;
            q.txd      <= 1'b1;
            q.txd_oe_n <= 1'b1;
            q.osc_req  <= 1'b1;
            q.clk_req  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign apb_rsp   = q.rsp;
    assign txd_o     = q.txd;
    assign txd_oe_n  = q.txd_oe_n;
    assign line_driver_direction_o    = q.line_driver_direction;
    assign osc_req_o = q.osc_req;
    assign clk_req_o = q.clk_req;
    assign irq_o     = q.irq;

endmodule

// [inc/ulm_map.svh]
// register offsets, field positions, reset values and timing counts of the line-mode uart
`ifndef ULM_MAP_SVH
`define ULM_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define ULM_OFF_CTRL_A      8'h00
`define ULM_OFF_CTRL_B      8'h04
`define ULM_OFF_CTRL_C      8'h08
`define ULM_OFF_BAUD        8'h0C
`define ULM_OFF_TXDATA      8'h10
`define ULM_OFF_RXDATA      8'h14
`define ULM_OFF_STATUS      8'h18
`define ULM_OFF_IRCTL       8'h1C

// ****************************************
// field positions
// ****************************************
`define ULM_A_RS485         0
`define ULM_A_LOOPBACK      3
`define ULM_A_RXS_IE        4
`define ULM_A_RXC_IE        7
`define ULM_B_SPD_LO        1
`define ULM_B_SPD_HI        2
`define ULM_B_OPEN_DRAIN    3
`define ULM_B_SOF_EN        4
`define ULM_B_TX_EN         6
`define ULM_B_RX_EN         7
`define ULM_C_STOP2         3
`define ULM_C_PAR_LO        4
`define ULM_C_PAR_HI        5
`define ULM_C_MODE_LO       6
`define ULM_C_MODE_HI       7
`define ULM_ST_TX_BUSY      0
`define ULM_ST_RX_BUSY      1
`define ULM_ST_RXS          4
`define ULM_ST_RXC          7
`define ULM_RD_PARITY_ERROR_FLAG         9
`define ULM_RD_FERR         10
`define ULM_RD_RXC          15

// ****************************************
// field values and reset values
// ****************************************
`define ULM_MODE_ASYNC      2'h0
`define ULM_MODE_IR         2'h2
`define ULM_PAR_EVEN        2'h2
`define ULM_PAR_ODD         2'h3
`define ULM_SPD_DOUBLE      2'h1
`define ULM_SPD_LIN         2'h3
`define ULM_IRTX_316        2'h0
`define ULM_IRTX_FIXED      2'h1
`define ULM_BAUD_RST        16'h001A
`define ULM_TXPL_RST        8'h00
`define ULM_RXPL_RST        7'h00

// ****************************************
// timing counts in baud ticks
// ****************************************
`define ULM_OVS_NORMAL      5'h10
`define ULM_OVS_DOUBLE      5'h08
`define ULM_IR_316_TICKS    5'h03

`endif

// [inc/ulm_pkg.sv]
// types of the line-mode uart: bus carriers, state machines and the state record
package ulm_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ulm_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ulm_apb_rsp_t;

    typedef enum logic [5:0] {
        TX_IDLE  = 6'h01,
        TX_GUARD = 6'h02,
        TX_START = 6'h04,
        TX_DATA  = 6'h08,
        TX_PAR   = 6'h10,
        TX_STOP  = 6'h20
    } ulm_tx_st_t;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'h01,
        RX_START = 5'h02,
        RX_DATA  = 5'h04,
        RX_PAR   = 5'h08,
        RX_STOP  = 5'h10
    } ulm_rx_st_t;

    typedef enum logic [2:0] {
        LIN_WAIT = 3'h1,
        LIN_SYNC = 3'h2,
        LIN_PID  = 3'h4
    } ulm_lin_st_t;

    typedef struct packed {
        logic [2:0]   sync1;
        logic [2:0]   sync2;
        logic [7:0]   ctrl_a;
        logic [7:0]   ctrl_b;
        logic [7:0]   ctrl_c;
        logic [15:0]  baud;
        logic [15:0]  baud_cnt;
        logic [7:0]   txpl;
        logic [6:0]   rxpl;
        logic [1:0]   irtx_mode;
        logic         ir_evsel;
        ulm_tx_st_t   tx_st;
        logic [4:0]   tx_sub;
        logic [2:0]   tx_bitn;
        logic         tx_stopn;
        logic [7:0]   tx_shift;
        logic         tx_par;
        logic [7:0]   tx_pw;
        ulm_rx_st_t   rx_st;
        logic [4:0]   rx_sub;
        logic [2:0]   rx_bitn;
        logic [7:0]   rx_shift;
        logic         rx_parbit;
        logic         rx_prev;
        logic [7:0]   rx_data;
        logic         parity_error_flag;
        logic         ferr;
        logic         rxc;
        logic         rxs;
        ulm_lin_st_t  lin_st;
        logic [6:0]   ir_cnt;
        logic [4:0]   ir_low;
        logic         sof_woke;
        logic         osc_hold;
        logic         clk_wake;
        logic         txd;
        logic         txd_oe_n;
        logic         line_driver_direction;
        logic         irq;
        logic         osc_req;
        logic         clk_req;
        ulm_apb_rsp_t rsp;
    } ulm_state_t;

endpackage

// [tb/ulm_core_asserts.sv]
// port checker of the line-mode uart
`timescale 1ns/10ps
module ulm_core_asserts (
    // clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // register bus
    input wire ulm_pkg::ulm_apb_req_t apb_req,
    input wire ulm_pkg::ulm_apb_rsp_t apb_rsp,
    // pins and power
    input wire logic                  txd_o,
    input wire logic                  txd_oe_n,
    input wire logic                  line_driver_direction_o,
    input wire logic                  standby_i,
    input wire logic                  osc_req_o,
    input wire logic                  clk_req_o
);
    import ulm_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****
    // helpers
    // ****
    wire acc = apb_req.psel && apb_req.penable && !apb_rsp.pready;
    // released or driven high both read as an idle line
    wire line_hi = txd_oe_n || txd_o;
    a_ready_wait: assert property (acc |=> apb_rsp.pready)
        else $error("pready missing after access");
    a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
        else $error("pslverr without pready or with data");
    a_unmapped_err: assert property (acc && apb_req.paddr[1:0] != 2'h0 |=> apb_rsp.pslverr)
        else $error("unaligned access not refused");
    a_awake_clocks: assert property (!standby_i |=> osc_req_o && clk_req_o)
        else $error("clock requests low while awake");
    a_guard_idle: assert property ($rose(line_driver_direction_o) |-> line_hi [*8])
        else $error("line left idle too early after direction rise");
    a_dir_release: assert property ($fell(line_driver_direction_o) |-> line_hi && $past(line_hi))
        else $error("direction fell before stop bit ended");
    a_dir_hold: assert property (line_driver_direction_o && !line_hi |=> line_driver_direction_o)
        else $error("direction dropped in mid frame");
    c_dir: cover property ($rose(line_driver_direction_o));
    c_err: cover property (apb_rsp.pslverr);
    c_wake: cover property (standby_i && clk_req_o);
endmodule

bind ulm_core ulm_core_asserts chk_u (
    .pclk      (pclk),
    .presetn   (presetn),
    .apb_req   (apb_req),
    .apb_rsp   (apb_rsp),
    .txd_o     (txd_o),
    .txd_oe_n  (txd_oe_n),
    .line_driver_direction_o    (line_driver_direction_o),
    .standby_i (standby_i),
    .osc_req_o (osc_req_o),
    .clk_req_o (clk_req_o)
);

// [tb/ulm_line_model.sv]
// remote station: receive pin driver and pulled-up shared tx wire
`timescale 1ns/10ps
module ulm_line_model (
    // clock
    input wire logic pclk,
    // uart tx pin
    input wire logic txd_o,
    input wire logic txd_oe_n,
    // line levels
    output logic     rxd,
    output logic     txd_wire
);
    // idle high through the pin pull-up
    initial rxd = 1'b1;
    assign txd_wire = txd_oe_n ? 1'b1 : txd_o;
    // 16 clocks a bit, lsb first
    task send(input logic [10:0] f);
        for (int i = 0; i < 11; i++) begin
            @(posedge pclk);
            rxd <= f[i];
            repeat (15) @(posedge pclk);
        end
    endtask
endmodule

// [tb/tb_ulm_core.sv]
// self-checking bench of the line-mode uart
`timescale 1ns/10ps
module tb_ulm_core;
    import ulm_pkg::*;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic        e;
    } ulm_row_t;
    logic         pclk;
    logic         presetn;
    ulm_apb_req_t req;
    ulm_apb_rsp_t rsp;
    logic         txd_o, txd_oe_n, line_driver_direction_o, wire_l, rxd;
    logic         standby, evt, owk, osc, clk_rq, irq, er;
    logic [31:0]  rd;
    logic [10:0]  f;
    int           n_mismatch, check_count, n;
    ulm_row_t rows [9] = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h0C, 0, 32'h1A, 0},
        '{0, 8'h1C, 0, 0, 0}, '{0, 8'h22, 0, 0, 1}, '{0, 8'h20, 0, 0, 1},
        '{1, 8'h10, 32'h55, 0, 0}, '{0, 8'h18, 0, 0, 0},
        '{1, 8'h0C, 0, 0, 0}, '{0, 8'h0C, 0, 0, 0}};
    ulm_core uut (
        .pclk         (pclk),
        .presetn      (presetn),
        .apb_req      (req),
        .apb_rsp      (rsp),
        .rxd_i        (rxd),
        .txd_i        (wire_l),
        .txd_o        (txd_o),
        .txd_oe_n     (txd_oe_n),
        .line_driver_direction_o       (line_driver_direction_o),
        .ir_event_i   (evt),
        .standby_i    (standby),
        .other_wake_i (owk),
        .osc_req_o    (osc),
        .clk_req_o    (clk_rq),
        .irq_o        (irq)
    );
    ulm_line_model m (
        .pclk     (pclk),
        .txd_o    (txd_o),
        .txd_oe_n (txd_oe_n),
        .rxd      (rxd),
        .txd_wire (wire_l)
    );
    // ****
    // tasks
    // ****
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask
    task automatic await(ref logic s, input logic v);
        int k;
        k = 0;
        while (s !== v && k < 400) begin
            @(posedge pclk);
            k++;
        end
        chk("wait", 1, k < 400);
    endtask
    task results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // generous: whole run is about two thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        results();
    end
    initial begin
        presetn = 1'b0;
        req = '0;
        standby = 1'b0;
        evt = 1'b0;
        owk = 1'b0;
        repeat (16) @(posedge pclk);
        chk("reset pins", 32'h23, {txd_oe_n, line_driver_direction_o, irq, rsp.pready, osc, clk_rq});
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("pslverr", rows[i].e, er);
            if (!rows[i].w) chk("prdata", rows[i].x, rd);
        end
        // rs485 + loopback + open drain; rxd held low must not reach receiver
        for (int p = 0; p < 2; p++) begin
            m.rxd <= 1'b0;
            apb(1, 8'h00, 32'h09);
            apb(1, 8'h04, 32'hC8);
            apb(1, 8'h08, p ? 32'h30 : 32'h20);
            apb(1, 8'h10, 32'h07);
            await(line_driver_direction_o, 1'b1);
            await(wire_l, 1'b0);
            repeat (8) @(posedge pclk);
            for (int i = 0; i < 11; i++) begin
                f[i] = wire_l;
                chk("line_driver_direction", 3'h4, {line_driver_direction_o, !txd_oe_n && txd_o, txd_oe_n && !f[i]});
                repeat (16) @(posedge pclk);
            end
            chk("frame", {1'b1, ~p[0], 8'h07, 1'b0}, f);
            chk("line_driver_direction end", 0, line_driver_direction_o);
            apb(0, 8'h14, 0);
            chk("own frame", 32'h8007, rd);
        end
        m.rxd <= 1'b1;
        apb(1, 8'h00, 0);
        apb(1, 8'h04, 32'h80);
        for (int b = 0; b < 2; b++) begin
            m.send({1'b1, ~b[0], 8'h07, 1'b0});
            apb(0, 8'h14, 0);
            chk("rx parity", {16'h0, 1'b1, 5'h0, ~b[0], 9'h007}, rd);
        end
        // lin: break, sync, then an identifier whose second parity bit is wrong
        apb(1, 8'h08, 0);
        apb(1, 8'h04, 32'h86);
        m.send(11'h400);
        m.send({2'h3, 8'h55, 1'b0});
        m.send({2'h3, 8'h00, 1'b0});
        apb(0, 8'h14, 0);
        chk("lin pid", 32'h8200, rd);
        apb(1, 8'h04, 32'h40);
        apb(1, 8'h08, 32'h80);
        apb(1, 8'h10, 0);
        await(wire_l, 1'b0);
        n = 0;
        while (wire_l === 1'b0 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk("ir pulse", 3, n);
        // standby during a frame must not drop the oscillator
        standby <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("busy osc", 2, {osc, clk_rq});
        repeat (200) @(posedge pclk);
        apb(1, 8'h08, 0);
        apb(1, 8'h00, 32'h10);
        apb(1, 8'h04, 32'h90);
        standby <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("asleep", 0, {osc, clk_rq});
        m.rxd <= 1'b0;
        repeat (3) @(posedge pclk);
        m.rxd <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("woken", 7, {osc, clk_rq, irq});
        repeat (30) @(posedge pclk);
        chk("false start", 1, {osc, clk_rq, irq});
        apb(0, 8'h18, 0);
        chk("start flag", 1, rd[4]);
        // a second glitch with another wake source pending keeps everything up
        owk <= 1'b1;
        m.rxd <= 1'b0;
        repeat (3) @(posedge pclk);
        m.rxd <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("other wake", 7, {osc, clk_rq, irq});
        standby <= 1'b0;
        owk <= 1'b0;
        // infrared receive from the event channel; pin held low to show it is cut off
        apb(1, 8'h08, 32'h80);
        apb(1, 8'h1C, 32'h01000400);
        m.rxd <= 1'b0;
        f = {2'h3, 8'hA5, 1'b0};
        // long pulses decode as zero, two-clock pulses must be dropped
        for (int i = 0; i < 10; i++) begin
            evt <= 1'b1;
            repeat (f[i] ? 2 : 6) @(posedge pclk);
            evt <= 1'b0;
            repeat (f[i] ? 14 : 10) @(posedge pclk);
        end
        apb(0, 8'h14, 0);
        chk("ir rx", 32'h80A5, rd);
        results();
    end
endmodule
